// ===== shared/cmb_consts.svh
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH
// Byte offsets of the register page.
`define CMB_OFS_ERR_STATUS   8'h70
`define CMB_OFS_ERR_IRQ_EN   8'h71
`define CMB_OFS_TX_ERR_CNT   8'h72
`define CMB_OFS_RX_ERR_CNT   8'h73
`define CMB_OFS_TIMING_A     8'h74
`define CMB_OFS_TIMING_B     8'h75
`define CMB_OFS_FMODE_A      8'h78
`define CMB_OFS_FMODE_B      8'h79
`define CMB_OFS_FCFG_0       8'h7A
`define CMB_OFS_FCFG_1       8'h7B
`define CMB_OFS_FCFG_2       8'h7C
`define CMB_OFS_STAMP_LO     8'h7E
`define CMB_OFS_STAMP_HI     8'h7F
`define CMB_OFS_MBOX_CS      8'h60
`define CMB_OFS_GTX_STATUS   8'h61
// Field positions in the mailbox control/status byte.
`define CMB_BIT_TX_REQUEST_BIT         0
`define CMB_BIT_ABORT_REQUEST_BIT         1
`define CMB_BIT_DONE         2
`define CMB_BIT_OK           3
`define CMB_BIT_ARBITRATION_LOST_FLAG         4
`define CMB_BIT_TX_FAIL_ERROR_FLAG         5
// Field positions in the global transmit status byte.
`define CMB_GBIT_DONE        0
`define CMB_GBIT_OK          1
`define CMB_GBIT_EMPTY       2
// Reset values.
`define CMB_RST_TIMING_B     8'h23
`define CMB_RST_ZERO         8'h00
// Writable masks.
`define CMB_MASK_ERR_STATUS  8'h70
`define CMB_MASK_TIMING_B    8'h7F
`define CMB_MASK_FMODE_B     8'h0F
`endif

// ===== shared/cmb_pkg.sv
package cmb_pkg;
    // Register bus request from software.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cmb_bus_req_type;
    // Outcome of one transmission attempt, a one-cycle report from the engine.
    typedef struct packed {
        logic done;
        logic ok;
        logic arb_lost;
        logic error;
        logic aborted;
    } cmb_attempt_type;
    // Error state supplied by the protocol engine.
    typedef struct packed {
        logic [2:0] last_error_code;
        logic       bus_off_flag;
        logic       error_passive_flag;
        logic       error_warning_flag;
    } cmb_err_state_type;
    typedef enum logic [1:0] {
        CMB_EMPTY   = 2'b00,
        CMB_PENDING = 2'b01,
        CMB_ABORTNG = 2'b10
    } cmb_mbox_state_type;
endpackage

// ===== design/cmb_tx_mailbox.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`include "cmb_consts.svh"
// Overview of operation
// - Mailbox status bits 7:6 always read zero.
// - Error flag updated after each attempt.
// - Arbitration-lost flag updated after each attempt.
// - Success flag updated, mirrored in global status.
// - Done flag set when request carried out.
// - Write-one clears done; new request clears.
// - Done flag equals global per-mailbox done bit.
// - Clearing done clears all attempt status.
// - Abort bit set by software, cleared empty unless written as it empties.
// - Abort ignored while nothing pending.
// - Transmit bit set by software, cleared empty.
// - Receive mailbox shows match index instead.
// - Sixteen-bit stamp in two read-only bytes.
// - Two eight-bit error counters, reset zero.
// - First timing: jump width, baud prescaler.
// - Second timing: segments, reset 010/0011.
// - Six filter mode pairs in two registers.
// - Six filter configs, two per register.
// - Mailbox writable only while empty.
module cmb_tx_mailbox
    import cmb_pkg::*;
#(
    parameter bit IS_RX_MAILBOX = 1'b0
)
(
    input  wire logic              core_clk,        // System clock, 100 MHz.
    input  wire logic              arst_n,          // Asynchronous reset, active low.
    input  wire cmb_bus_req_type   bus_req,         // Register strobes, address and write data.
    output logic [7:0]             bus_rdata,       // Read data, valid the cycle after a read.
    output logic                   mbox_write_en,   // Mailbox payload may be written.
    output logic                   tx_pending,      // Transmission requested to the engine.
    output logic                   abort_pending,   // Abort requested to the engine.
    input  wire cmb_attempt_type   attempt,         // Attempt report from the protocol engine.
    input  wire cmb_err_state_type err_state,       // Error state from the protocol engine.
    input  wire logic              err_state_valid, // Load error state this cycle.
    input  wire logic [7:0]        tx_err_count,    // Transmit error counter of the engine.
    input  wire logic [7:0]        rx_err_count,    // Receive error counter of the engine.
    input  wire logic [15:0]       stamp_value,     // Time stamp captured on the frame.
    input  wire logic              stamp_valid,     // Load the time stamp this cycle.
    input  wire logic [7:0]        match_index,     // Filter match index for receive use.
    output logic [7:0]             timing_a,        // First bit timing byte.
    output logic [7:0]             timing_b,        // Second bit timing byte.
    output logic [11:0]            filter_mode,     // Upper/lower mode bits, two per filter.
    output logic [23:0]            filter_cfg       // Four config bits per filter.
);

    cmb_mbox_state_type state_q;
    logic       tx_request_bit_q;
    logic       abort_request_bit_q;
    logic       done_q;
    logic       ok_q;
    logic       arbitration_lost_flag_q;
    logic       tx_fail_error_flag_q;
    logic [7:0] err_status_q;
    logic [7:0] irq_en_q;
    logic [7:0] tec_q;
    logic [7:0] rec_q;
    logic [7:0] timing_a_q;
    logic [7:0] timing_b_q;
    logic [7:0] fmode_a_q;
    logic [7:0] fmode_b_q;
    logic [7:0] fcfg_q [0:2];
    logic [15:0] stamp_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] mbox_cs;
    logic [7:0] gtx_status;

    logic wr_cs;
    logic wr_new_tx;
    logic wr_abort;
    logic wr_clear;
    logic is_empty;

    // Software reaches the control byte only in a transmit mailbox.
    assign wr_cs     = bus_req.wr && (bus_req.addr == `CMB_OFS_MBOX_CS) && !IS_RX_MAILBOX;
    assign is_empty  = (state_q == CMB_EMPTY);
    // A new request is accepted only from an empty mailbox; a second write is harmless.
    assign wr_new_tx = wr_cs && bus_req.wdata[`CMB_BIT_TX_REQUEST_BIT] && is_empty;
    assign wr_abort  = wr_cs && bus_req.wdata[`CMB_BIT_ABORT_REQUEST_BIT] && (state_q == CMB_PENDING);
    assign wr_clear  = wr_cs && bus_req.wdata[`CMB_BIT_DONE];

    // Mailbox life cycle: empty, pending, and pending with an abort in flight.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= CMB_EMPTY;
        end
        else
        begin
            case (state_q)
                CMB_EMPTY:
                begin
                    if (wr_new_tx)
                    begin
                        state_q <= CMB_PENDING;
                    end
                end
                CMB_PENDING:
                begin
                    if (attempt.done && (attempt.ok || attempt.aborted))
                    begin
                        state_q <= CMB_EMPTY;
                    end
                    else if (wr_abort)
                    begin
                        state_q <= CMB_ABORTNG;
                    end
                end
                CMB_ABORTNG:
                begin
                    // A failed attempt after the abort request also ends the job.
                    if (attempt.done)
                    begin
                        state_q <= CMB_EMPTY;
                    end
                end
                default:
                begin
                    state_q <= CMB_EMPTY;
                end
            endcase
        end
    end

    // Request bits follow the state; both drop when the mailbox empties, except an abort written in that same cycle, which stays set.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_request_bit_q <= 1'b0;
            abort_request_bit_q <= 1'b0;
        end
        else
        begin
            if (wr_new_tx)
            begin
                tx_request_bit_q <= 1'b1;
            end
            else if (!is_empty && attempt.done && (attempt.ok || attempt.aborted || state_q == CMB_ABORTNG))
            begin
                tx_request_bit_q <= 1'b0;
            end
            if (wr_abort)
            begin
                abort_request_bit_q <= 1'b1;
            end
            else if (!is_empty && attempt.done && (attempt.ok || attempt.aborted || state_q == CMB_ABORTNG))
            begin
                abort_request_bit_q <= 1'b0;
            end
        end
    end

    // Attempt status. An attempt report wins over a software clear in the same cycle.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            done_q <= 1'b0;
            ok_q   <= 1'b0;
            arbitration_lost_flag_q <= 1'b0;
            tx_fail_error_flag_q <= 1'b0;
        end
        else if (attempt.done && !is_empty)
        begin
            ok_q   <= attempt.ok && !attempt.aborted;
            arbitration_lost_flag_q <= attempt.arb_lost && !attempt.ok;
            tx_fail_error_flag_q <= attempt.error && !attempt.ok;
            if (attempt.ok || attempt.aborted || state_q == CMB_ABORTNG)
            begin
                done_q <= 1'b1;
            end
        end
        else if (wr_clear || wr_new_tx)
        begin
            done_q <= 1'b0;
            ok_q   <= 1'b0;
            arbitration_lost_flag_q <= 1'b0;
            tx_fail_error_flag_q <= 1'b0;
        end
    end

    // Error status and counters are loaded from the protocol engine.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            err_status_q <= `CMB_RST_ZERO;
            tec_q        <= `CMB_RST_ZERO;
            rec_q        <= `CMB_RST_ZERO;
        end
        else
        begin
            tec_q <= tx_err_count;
            rec_q <= rx_err_count;
            if (err_state_valid)
            begin
                err_status_q <= {1'b0, err_state.last_error_code, 1'b0, err_state.bus_off_flag,
                                 err_state.error_passive_flag, err_state.error_warning_flag};
            end
            else if (bus_req.wr && bus_req.addr == `CMB_OFS_ERR_STATUS)
            begin
                // Software may only rewrite the error code field.
                err_status_q <= (err_status_q & ~`CMB_MASK_ERR_STATUS) | (bus_req.wdata & `CMB_MASK_ERR_STATUS);
            end
        end
    end

    // The stamp has no reset; its contents are undefined until the first frame.
    always_ff @(posedge core_clk)
    begin
        if (stamp_valid)
        begin
            stamp_q <= stamp_value;
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_en_q   <= `CMB_RST_ZERO;
            timing_a_q <= `CMB_RST_ZERO;
            timing_b_q <= `CMB_RST_TIMING_B;
            fmode_a_q  <= `CMB_RST_ZERO;
            fmode_b_q  <= `CMB_RST_ZERO;
            fcfg_q[0]  <= `CMB_RST_ZERO;
            fcfg_q[1]  <= `CMB_RST_ZERO;
            fcfg_q[2]  <= `CMB_RST_ZERO;
        end
        else if (bus_req.wr)
        begin
            case (bus_req.addr)
                `CMB_OFS_ERR_IRQ_EN: irq_en_q   <= bus_req.wdata;
                `CMB_OFS_TIMING_A:   timing_a_q <= bus_req.wdata;
                `CMB_OFS_TIMING_B:   timing_b_q <= bus_req.wdata & `CMB_MASK_TIMING_B;
                `CMB_OFS_FMODE_A:    fmode_a_q  <= bus_req.wdata;
                `CMB_OFS_FMODE_B:    fmode_b_q  <= bus_req.wdata & `CMB_MASK_FMODE_B;
                `CMB_OFS_FCFG_0:     fcfg_q[0]  <= bus_req.wdata;
                `CMB_OFS_FCFG_1:     fcfg_q[1]  <= bus_req.wdata;
                `CMB_OFS_FCFG_2:     fcfg_q[2]  <= bus_req.wdata;
                default:
                begin
                end
            endcase
        end
    end

    // Both views read the same flops, so the mailbox byte and global status cannot disagree.
    assign mbox_cs    = {2'b00, tx_fail_error_flag_q, arbitration_lost_flag_q, ok_q, done_q, abort_request_bit_q, tx_request_bit_q};
    assign gtx_status = {5'b00000, is_empty, ok_q, done_q};

    // Read multiplexer; unmapped addresses read zero.
    always_comb
    begin
        rdata_d = 8'h00;
        case (bus_req.addr)
            `CMB_OFS_MBOX_CS:    rdata_d = IS_RX_MAILBOX ? match_index : mbox_cs;
            `CMB_OFS_GTX_STATUS: rdata_d = gtx_status;
            `CMB_OFS_ERR_STATUS: rdata_d = err_status_q;
            `CMB_OFS_ERR_IRQ_EN: rdata_d = irq_en_q;
            `CMB_OFS_TX_ERR_CNT: rdata_d = tec_q;
            `CMB_OFS_RX_ERR_CNT: rdata_d = rec_q;
            `CMB_OFS_TIMING_A:   rdata_d = timing_a_q;
            `CMB_OFS_TIMING_B:   rdata_d = timing_b_q;
            `CMB_OFS_FMODE_A:    rdata_d = fmode_a_q;
            `CMB_OFS_FMODE_B:    rdata_d = fmode_b_q;
            `CMB_OFS_FCFG_0:     rdata_d = fcfg_q[0];
            `CMB_OFS_FCFG_1:     rdata_d = fcfg_q[1];
            `CMB_OFS_FCFG_2:     rdata_d = fcfg_q[2];
            `CMB_OFS_STAMP_LO:   rdata_d = stamp_q[7:0];
            `CMB_OFS_STAMP_HI:   rdata_d = stamp_q[15:8];
            default:             rdata_d = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= bus_req.rd ? rdata_d : 8'h00;
        end
    end

    // Registered outputs toward the engine and the payload store.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mbox_write_en <= 1'b0;
            tx_pending    <= 1'b0;
            abort_pending <= 1'b0;
        end
        else
        begin
            mbox_write_en <= !IS_RX_MAILBOX && is_empty && !wr_new_tx;
            tx_pending    <= tx_request_bit_q;
            abort_pending <= abort_request_bit_q;
        end
    end

    assign bus_rdata   = rdata_q;
    assign timing_a    = timing_a_q;
    assign timing_b    = timing_b_q;
    assign filter_mode = {fmode_b_q[3:0], fmode_a_q};
    assign filter_cfg  = {fcfg_q[2], fcfg_q[1], fcfg_q[0]};

endmodule

// ===== tb/cmb_tx_mailbox_sva.sv
`timescale 1ns/1ns
// Watches the register port and the request lifecycle of one mailbox.
module cmb_tx_mailbox_sva
    import cmb_pkg::*;
(
    input wire logic            core_clk,      // Clock.
    input wire logic            arst_n,        // Reset, active low.
    input wire cmb_bus_req_type bus_req,       // Register request.
    input wire logic [7:0]      bus_rdata,     // Read data.
    input wire logic            mbox_write_en, // Mailbox writable.
    input wire logic            tx_pending,    // Transmit pending.
    input wire logic            abort_pending, // Abort pending.
    input wire cmb_attempt_type attempt,       // Engine report.
    input wire logic [7:0]      timing_a,      // First timing byte.
    input wire logic [7:0]      timing_b,      // Second timing byte.
    input wire logic [11:0]     filter_mode,   // Filter mode bits.
    input wire logic [23:0]     filter_cfg     // Filter config bits.
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Reads return the register as it stood when the strobe was taken.
    rsvd_bits_a: assert property (bus_req.rd && bus_req.addr == 8'h60 |=> bus_rdata[7:6] == 2'h0)
        else $error("reserved mailbox bits read as one");
    timing_rd_a: assert property (bus_req.rd && bus_req.addr == 8'h74 |=> bus_rdata == $past(timing_a))
        else $error("first timing read differs from its output");
    timing2_rd_a: assert property (bus_req.rd && bus_req.addr == 8'h75 |=> bus_rdata == $past(timing_b))
        else $error("second timing read differs from its output");
    fmode_rd_a: assert property (bus_req.rd && bus_req.addr == 8'h79 |=> bus_rdata == {4'h0, $past(filter_mode[11:8])})
        else $error("second filter mode read wrong");
    // Payload writes must be locked for as long as a transmission is pending.
    write_lock_a: assert property (tx_pending |-> !mbox_write_en)
        else $error("mailbox writable while pending");
    // mbox_write_en already drops the cycle after a request write; the previous-write guard only narrows the check.
    tx_start_a: assert property (bus_req.wr && bus_req.addr == 8'h60 && bus_req.wdata[0] && mbox_write_en
        && !$past(bus_req.wr) && !attempt.done |-> ##2 tx_pending)
        else $error("transmit request not taken");
    abort_ignore_a: assert property (bus_req.wr && bus_req.addr == 8'h60 && bus_req.wdata[1] && mbox_write_en
        && !tx_pending && !$past(bus_req.wr) |-> ##2 !abort_pending)
        else $error("abort taken on an empty mailbox");
    tx_done_a: assert property (attempt.done && attempt.ok && tx_pending |-> ##2 (!tx_pending && mbox_write_en))
        else $error("mailbox not emptied after success");
    // An abort written one cycle earlier is already in flight although its output has not risen yet.
    arb_retry_a: assert property (attempt.done && !attempt.ok && !attempt.aborted && tx_pending
        && !abort_pending && !$past(bus_req.wr) |-> ##2 tx_pending)
        else $error("failed attempt dropped the request");
    abort_done_a: assert property (attempt.done && attempt.aborted && abort_pending
        |-> ##2 (!abort_pending && !tx_pending))
        else $error("abort did not empty the mailbox");
    // Main scenarios that the bench is meant to reach.
    ok_seen_c: cover property (attempt.done && attempt.ok && tx_pending);
    lost_seen_c: cover property (attempt.done && attempt.arb_lost && tx_pending);
    abort_seen_c: cover property (attempt.done && attempt.aborted && abort_pending);
endmodule

bind cmb_tx_mailbox cmb_tx_mailbox_sva i_cmb_tx_mailbox_sva (.core_clk, .arst_n, .bus_req, .bus_rdata,
    .mbox_write_en, .tx_pending, .abort_pending, .attempt, .timing_a, .timing_b, .filter_mode, .filter_cfg);

// ===== tb/cmb_engine_model.sv
`timescale 1ns/1ns
// Stands in for the protocol engine: one attempt report for each go pulse taken while tx_pending is high.
module cmb_engine_model
    import cmb_pkg::*;
(
    input  wire logic       core_clk,      // Clock.
    input  wire logic       tx_pending,    // Transmit pending from the mailbox.
    input  wire logic       abort_pending, // Abort pending from the mailbox.
    input  wire logic       go,            // Start one attempt.
    input  wire logic [1:0] outcome,       // 0 ok, 1 arbitration lost, 2 error, 3 none; the abort flag follows abort_pending.
    input  wire logic [3:0] lat,           // Cycles before the report, prompt or slow.
    output cmb_attempt_type attempt        // One-cycle report.
);
    initial attempt = '0;
    // Like the real engine, it never reports on a mailbox that is not pending.
    always @(posedge core_clk)
    begin
        if (go && tx_pending)
        begin
            repeat (lat) @(posedge core_clk);
            attempt <= '{1'b1, outcome == 2'h0, outcome == 2'h1, outcome == 2'h2, abort_pending};
            @(posedge core_clk);
            attempt <= '0;
        end
    end
endmodule

// ===== tb/cmb_tx_mailbox_bench.sv
`timescale 1ns/1ns
module cmb_tx_mailbox_bench;
    import cmb_pkg::*;
    logic core_clk, arst_n, mbox_write_en, tx_pending, abort_pending, err_state_valid, stamp_valid, go;
    logic [7:0] bus_rdata, rx_rdata, rx_seen, tx_err_count, rx_err_count, match_index, timing_a, timing_b;
    logic [15:0] stamp_value;
    logic [11:0] filter_mode;
    logic [23:0] filter_cfg;
    logic [1:0] outcome;
    logic [3:0] lat;
    cmb_bus_req_type bus_req;
    cmb_attempt_type attempt;
    cmb_err_state_type err_state;
    int n_mismatch = 0;
    int compares = 0;
    logic [7:0] ofs [13] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h60, 8'h61};
    logic [7:0] rst [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h23, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
    logic [7:0] wex [11] = '{8'h70, 8'hFF, 8'h5A, 8'hA5, 8'hFF, 8'h7F, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF};

    cmb_tx_mailbox i_cmb_tx_mailbox (.*);
    // A receive mailbox shares the bus; only its read data is watched.
    cmb_tx_mailbox #(.IS_RX_MAILBOX(1'b1)) i_cmb_tx_mailbox_rx (.*, .bus_rdata(rx_rdata), .mbox_write_en(),
        .tx_pending(), .abort_pending(), .timing_a(), .timing_b(), .filter_mode(), .filter_cfg());
    cmb_engine_model i_cmb_engine_model (.*);

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample them at the edge that closes that cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        // Waiting for the edge rather than a delay keeps every later stimulus on a rising edge.
        @(posedge core_clk);
        rx_seen = rx_rdata;
        chk($sformatf("register %h", a), exp, bus_rdata);
    endtask

    task automatic mb(input logic [7:0] e0, input logic [7:0] e1);
        rd(8'h60, e0);
        rd(8'h61, e1);
    endtask

    // Asks the engine for one attempt and lets the report settle into the status bytes.
    task automatic eng(input logic [1:0] k, input logic [3:0] l);
        @(posedge core_clk);
        go <= 1'b1;
        outcome <= k;
        lat <= l;
        @(posedge core_clk);
        go <= 1'b0;
        for (int i = 0; i < 40 && attempt.done !== 1'b1; i++) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // The whole run is a few hundred cycles; this margin only trips on a hang.
    initial
    begin
        repeat (3000) @(posedge core_clk);
        n_mismatch++;
        $display("MISMATCH watchdog expected finish seen hang");
        results;
    end

    initial
    begin
        arst_n = 1'b0;
        bus_req = '0;
        err_state = '0;
        err_state_valid = 1'b0;
        stamp_value = 16'h0000;
        stamp_valid = 1'b0;
        tx_err_count = 8'h00;
        rx_err_count = 8'h00;
        match_index = 8'h2B;
        go = 1'b0;
        outcome = 2'h0;
        lat = 4'h0;
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 13; i++) rd(ofs[i], rst[i]);
        $display("reset values done");
        tx_err_count <= 8'h5A;
        rx_err_count <= 8'hA5;
        for (int i = 0; i < 11; i++) wr(ofs[i], 8'hFF);
        for (int i = 0; i < 11; i++) rd(ofs[i], wex[i]);
        chk("filter config output", 8'hFF, filter_cfg[23:16]);
        chk("filter mode output", 8'h0F, {4'h0, filter_mode[11:8]});
        $display("register access done");
        @(posedge core_clk);
        err_state <= '{3'h5, 1'b1, 1'b0, 1'b1};
        err_state_valid <= 1'b1;
        stamp_value <= 16'hBEEF;
        stamp_valid <= 1'b1;
        @(posedge core_clk);
        err_state_valid <= 1'b0;
        stamp_valid <= 1'b0;
        rd(8'h70, 8'h55);
        rd(8'h7E, 8'hEF);
        rd(8'h7F, 8'hBE);
        $display("engine state done");
        wr(8'h60, 8'h02);
        rd(8'h61, 8'h04);
        rd(8'h60, 8'h00);
        chk("receive mailbox byte", 8'h2B, rx_seen);
        wr(8'h60, 8'h01);
        mb(8'h01, 8'h00);
        chk("payload write enable", 8'h00, {7'h00, mbox_write_en});
        chk("transmit pending", 8'h01, {7'h00, tx_pending});
        eng(2'h1, 4'h0);
        mb(8'h11, 8'h00);
        eng(2'h2, 4'h5);
        mb(8'h21, 8'h00);
        eng(2'h0, 4'h3);
        mb(8'h0C, 8'h07);
        wr(8'h60, 8'hC0);
        mb(8'h0C, 8'h07);
        wr(8'h60, 8'h04);
        mb(8'h00, 8'h04);
        $display("transmit lifecycle done");
        wr(8'h60, 8'h01);
        eng(2'h0, 4'h0);
        wr(8'h60, 8'h01);
        mb(8'h01, 8'h00);
        wr(8'h60, 8'h03);
        mb(8'h03, 8'h00);
        eng(2'h3, 4'h2);
        mb(8'h04, 8'h05);
        chk("payload write enable", 8'h01, {7'h00, mbox_write_en});
        chk("abort pending", 8'h00, {7'h00, abort_pending});
        $display("abort done");
        results;
    end
endmodule
